// ==== core/icl_top.v ====
// isp pin clamp, flash programming, security and configuration loader
// assumes a jtag programmer on tck/tms/tdi/tdo and user logic on user_* ports
// Behaviour
// - plain isp entry floats every pin with its weak pull-up on.
// - sample clamp holds a pin's output value; sampled inputs stay floating.
// - under clamp each pin drives high, low, floats or holds independently.
// - real-time mode programs config flash while the running design keeps pins.
// - after real-time update the old design runs until a reconfigure command or the next power cycle.
// - reconfigure command reloads the logic array from config flash immediately.
// - during commanded reload all pins float with pull-ups for the load time.
// - with security set, config flash read-out returns nothing.
// - only a full device erase clears the security bit, with everything else.
// - the logic array configuration storage has no external access path.
// - user flash stays readable over jtag and logic array regardless of security.
// - user flash and config flash are programmed and read independently.
// - pins stay undriven until power is good and configuration has finished.
// - pins stay undriven by the user design until the program complete bit is programmed; clamp codes can drive them before.
// - an erase completes after the erase pulse time spent in run-test-idle.
// - each program completes after the program pulse time in run-test-idle.
// - user registers are cleared and released before the pins are released.
`timescale 1ns/1ps
`default_nettype none
`include "icl_defs.vh"
module icl_top #(
  parameter [31:0] ERASE_CYC = `ICL_ERASE_CYC, // erase pulse in cycles
  parameter [31:0] PROG_CYC = `ICL_PROG_CYC, // program pulse in cycles
  parameter [31:0] LOAD_CYC = `ICL_LOAD_CYC // config load time, at least 16
) (
  input wire clock, // 125 mhz system clock
  input wire reset, // async reset, high; models a power cycle
  input wire ce, // clock enable, freezes all state when low
  input wire tck, // jtag clock pin
  input wire tms, // jtag mode select pin
  input wire tdi, // jtag data in pin
  output wire tdo, // jtag data out
  output wire tdo_oe, // tdo driven while shifting
  input wire power_good, // supplies in range, pin
  input wire [7:0] user_out, // user design output values
  input wire [7:0] user_oe, // user design output enables
  output wire [7:0] pin_out, // pin output value
  output wire [7:0] pin_oe, // pin output enable
  output wire [7:0] pin_pullup, // weak pull-up enable
  output wire user_reset, // clear to the user registers, high
  input wire [3:0] cfg_addr, // logic array config word select
  output wire [15:0] cfg_data, // loaded config word
  input wire [3:0] ufm_addr, // logic array user flash read address
  output wire [15:0] ufm_data, // user flash word
  output wire isp_active // isp mode entered
);
  localparam [1:0] L_WAIT = 2'h0;
  localparam [1:0] L_LOAD = 2'h1;
  localparam [1:0] L_CLEAR = 2'h2;
  localparam [1:0] L_RUN = 2'h3;
  integer i;
  // ***********************************
  // pin synchronisers
  // ***********************************
  reg tck_m_q, tck_s_q, tck_p_q, tms_m_q, tms_s_q, tdi_m_q, tdi_s_q, pg_m_q, pg_s_q;
  // two stages for every outside input; edges taken from the second stage only
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      {tck_m_q, tck_s_q, tck_p_q, tms_m_q, tms_s_q} <= 5'h00;
      {tdi_m_q, tdi_s_q, pg_m_q, pg_s_q} <= 4'h0;
    end else if (ce) begin
      {tck_m_q, tck_s_q, tck_p_q} <= {tck, tck_m_q, tck_s_q};
      {tms_m_q, tms_s_q} <= {tms, tms_m_q};
      {tdi_m_q, tdi_s_q} <= {tdi, tdi_m_q};
      {pg_m_q, pg_s_q} <= {power_good, pg_m_q};
    end
  end
  wire tck_rise = tck_s_q & ~tck_p_q;
  wire tck_fall = ~tck_s_q & tck_p_q;
  wire [3:0] tap_st;
  icl_tap u_tap (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .tck_rise(tck_rise),
    .tms(tms_s_q),
    .state_q(tap_st)
  );
  // ***********************************
  // storage
  // ***********************************
  // flash arrays and bits are non-volatile: reset leaves them alone
  reg [15:0] cfm_mem [0:15];
  reg [15:0] ufm_mem [0:15];
  reg [15:0] sram_mem [0:15];
  reg sec_q, done_q;
  reg [3:0] ir_q, ir_sr_q, addr_q;
  reg [19:0] sr_q;
  reg [15:0] data_q, cset_q, cfg_data_q, ufm_data_q;
  reg [7:0] hold_q, hold_oe_q;
  reg [2:0] op_q;
  reg [31:0] cnt_q, lcnt_q;
  reg isp_q, clamp_q, rt_q, release_q, reconf_q, tdo_q, tdo_oe_q, ures_q;
  reg [1:0] lst_q;
  wire acc = isp_q | rt_q;
  wire erase_op = (op_q == `ICL_OP_ERASE) || (op_q == `ICL_OP_ERASE_UFM);
  wire [31:0] target = erase_op ? ERASE_CYC : PROG_CYC;
  wire op_fire = ce && (op_q != `ICL_OP_NONE) && (tap_st == `ICL_RTI) && (cnt_q == target - 1);
  // ***********************************
  // jtag instruction and data handling
  // ***********************************
  // acts on a sampled tck rising edge, tdo moves on the falling edge
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ir_q <= `ICL_I_BYPASS;
      ir_sr_q <= 4'h0;
      sr_q <= `ICL_DR_RST;
      addr_q <= 4'h0;
      data_q <= 16'h0000;
      cset_q <= 16'h0000;
      hold_q <= 8'h00;
      hold_oe_q <= 8'h00;
      op_q <= `ICL_OP_NONE;
      cnt_q <= 32'h00000000;
      {isp_q, clamp_q, rt_q, release_q, reconf_q, tdo_q, tdo_oe_q} <= 7'h00;
    end else if (ce) begin
      release_q <= 1'b0;
      reconf_q <= 1'b0;
      if (tck_rise) begin
        case (tap_st)
          `ICL_TLR: begin
            ir_q <= `ICL_I_BYPASS;
            op_q <= `ICL_OP_NONE;
          end
          `ICL_CAP_IR: ir_sr_q <= `ICL_IR_CAPTURE;
          `ICL_SH_IR: ir_sr_q <= {tdi_s_q, ir_sr_q[3:1]};
          `ICL_UPD_IR: begin
            ir_q <= ir_sr_q;
            op_q <= `ICL_OP_NONE;
            if (ir_sr_q == `ICL_I_ENTER && lst_q == L_RUN) begin
              isp_q <= 1'b1;
              clamp_q <= 1'b0;
            end
            if (ir_sr_q == `ICL_I_CLAMP && lst_q == L_RUN) begin
              isp_q <= 1'b1;
              clamp_q <= 1'b1;
              hold_q <= user_out;
              hold_oe_q <= user_oe;
            end
            if (ir_sr_q == `ICL_I_EXIT && acc) begin
              isp_q <= 1'b0;
              clamp_q <= 1'b0;
              rt_q <= 1'b0;
              release_q <= isp_q;
            end
            if (ir_sr_q == `ICL_I_RTISP && lst_q == L_RUN && !isp_q) begin
              rt_q <= 1'b1;
            end
            if (ir_sr_q == `ICL_I_RECONF && acc) begin
              reconf_q <= 1'b1;
              {isp_q, clamp_q, rt_q} <= 3'h0;
            end
            if (acc && ir_sr_q == `ICL_I_ERASE) op_q <= `ICL_OP_ERASE;
            if (acc && ir_sr_q == `ICL_I_SET_SEC) op_q <= `ICL_OP_SET_SEC;
            if (acc && ir_sr_q == `ICL_I_SET_DONE) op_q <= `ICL_OP_SET_DONE;
          end
          `ICL_CAP_DR: begin
            // no instruction reaches sram_mem from outside
            if (acc && ir_q == `ICL_I_READ_CFM) begin
              sr_q <= {addr_q, sec_q ? 16'h0000 : cfm_mem[addr_q]};
            end else if (acc && ir_q == `ICL_I_READ_UFM) begin
              sr_q <= {addr_q, ufm_mem[addr_q]};
            end else begin
              sr_q <= `ICL_DR_RST;
            end
          end
          `ICL_SH_DR: sr_q <= {tdi_s_q, sr_q[19:1]};
          `ICL_UPD_DR: begin
            // clamp settings only change outside isp
            if (ir_q == `ICL_I_LDCLAMP && !isp_q) cset_q <= sr_q[15:0];
            if (acc) begin
              addr_q <= sr_q[19:`ICL_DR_ADDR_LSB];
              data_q <= sr_q[15:0];
              if (ir_q == `ICL_I_PROG_CFM) op_q <= `ICL_OP_PROG_CFM;
              if (ir_q == `ICL_I_PROG_UFM) op_q <= `ICL_OP_PROG_UFM;
              if (ir_q == `ICL_I_ERASE_UFM) op_q <= `ICL_OP_ERASE_UFM;
            end
          end
          default: ;
        endcase
      end
      if (tck_fall) begin
        tdo_oe_q <= (tap_st == `ICL_SH_IR) || (tap_st == `ICL_SH_DR);
        tdo_q <= (tap_st == `ICL_SH_IR) ? ir_sr_q[0] : sr_q[0];
      end
      // pulse timer runs only in run-test-idle; leaving it restarts the pulse
      if (op_fire) begin
        op_q <= `ICL_OP_NONE;
        cnt_q <= 32'h00000000;
      end else if (op_q != `ICL_OP_NONE && tap_st == `ICL_RTI) begin
        cnt_q <= cnt_q + 32'h00000001;
      end else begin
        cnt_q <= 32'h00000000;
      end
    end
  end
  // ***********************************
  // flash array writes
  // ***********************************
  // programming only clears bits; erase is the one way back to ones
  always @(posedge clock) begin
    if (op_fire) begin
      case (op_q)
        `ICL_OP_ERASE: begin
          for (i = 0; i < 16; i = i + 1) begin
            cfm_mem[i] <= `ICL_ERASED;
            ufm_mem[i] <= `ICL_ERASED;
          end
          sec_q <= 1'b0;
          done_q <= 1'b0;
        end
        `ICL_OP_ERASE_UFM: begin
          for (i = 0; i < 16; i = i + 1) begin
            if (i[3] == addr_q[3]) ufm_mem[i] <= `ICL_ERASED;
          end
        end
        `ICL_OP_PROG_CFM: cfm_mem[addr_q] <= cfm_mem[addr_q] & data_q;
        `ICL_OP_PROG_UFM: ufm_mem[addr_q] <= ufm_mem[addr_q] & data_q;
        `ICL_OP_SET_SEC: sec_q <= 1'b1;
        `ICL_OP_SET_DONE: done_q <= 1'b1;
        default: ;
      endcase
    end
  end
  // ***********************************
  // configuration loader
  // ***********************************
  // sram copy runs one word a cycle during the load
  always @(posedge clock) begin
    if (ce && lst_q == L_LOAD) sram_mem[lcnt_q[3:0]] <= cfm_mem[lcnt_q[3:0]];
  end
  // wait for power, load, clear user registers, then run
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      lst_q <= L_WAIT;
      lcnt_q <= 32'h00000000;
      ures_q <= 1'b1;
      cfg_data_q <= 16'h0000;
      ufm_data_q <= 16'h0000;
    end else if (ce) begin
      cfg_data_q <= sram_mem[cfg_addr];
      ufm_data_q <= ufm_mem[ufm_addr];
      case (lst_q)
        L_WAIT: begin
          ures_q <= 1'b1;
          lcnt_q <= 32'h00000000;
          if (pg_s_q) lst_q <= L_LOAD;
        end
        L_LOAD: begin
          if (!pg_s_q) lst_q <= L_WAIT;
          else if (lcnt_q == LOAD_CYC - 1) lst_q <= L_CLEAR;
          else lcnt_q <= lcnt_q + 32'h00000001;
        end
        L_CLEAR: begin
          lst_q <= L_RUN;
          ures_q <= 1'b0;
        end
        default: begin
          if (!pg_s_q) begin
            lst_q <= L_WAIT; // brown-out
            ures_q <= 1'b1;
          end else if (reconf_q) begin
            lst_q <= L_LOAD;
            lcnt_q <= 32'h00000000;
            ures_q <= 1'b1;
          end
        end
      endcase
    end
  end
  // ***********************************
  // pin control
  // ***********************************
  // returns {oe, out, pullup} for one clamp code
  function [2:0] clamp_fn;
    input [1:0] code;
    input hv;
    input hoe;
    begin
      case (code)
        `ICL_CL_LOW: clamp_fn = 3'h4;
        `ICL_CL_HIGH: clamp_fn = 3'h6;
        `ICL_CL_SAMPLE: clamp_fn = hoe ? {1'b1, hv, 1'b0} : `ICL_PIN_FLOAT;
        default: clamp_fn = `ICL_PIN_FLOAT;
      endcase
    end
  endfunction
  // user drives only when running, complete bit set, and not in isp;
  // a pending reload or a supply drop floats the pins in that same cycle
  wire drive_user = (lst_q == L_RUN) && pg_s_q && !reconf_q && done_q
    && !isp_q && !release_q;
  reg [7:0] oe_q, out_q, pull_q;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          {oe_q[g], out_q[g], pull_q[g]} <= `ICL_PIN_FLOAT;
        end else if (ce) begin
          if (drive_user) begin
            {oe_q[g], out_q[g], pull_q[g]} <= {user_oe[g], user_out[g], 1'b0};
          end else if (isp_q && clamp_q) begin
            {oe_q[g], out_q[g], pull_q[g]} <=
              clamp_fn(cset_q[2*g+1:2*g], hold_q[g], hold_oe_q[g]);
          end else begin
            {oe_q[g], out_q[g], pull_q[g]} <= `ICL_PIN_FLOAT;
          end
        end
      end
    end
  endgenerate
  assign pin_oe = oe_q;
  assign pin_out = out_q;
  assign pin_pullup = pull_q;
  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign user_reset = ures_q;
  assign cfg_data = cfg_data_q;
  assign ufm_data = ufm_data_q;
  assign isp_active = isp_q;
endmodule
`default_nettype wire

// ==== pkg/icl_defs.vh ====
// constants shared by the isp clamp and configuration loader block
// assumes inclusion by bare name from the core files
`ifndef ICL_DEFS_VH
`define ICL_DEFS_VH
// ***********************************
// tap controller state codes
// ***********************************
`define ICL_TLR 4'h0
`define ICL_RTI 4'h1
`define ICL_SEL_DR 4'h2
`define ICL_CAP_DR 4'h3
`define ICL_SH_DR 4'h4
`define ICL_EX1_DR 4'h5
`define ICL_PA_DR 4'h6
`define ICL_EX2_DR 4'h7
`define ICL_UPD_DR 4'h8
`define ICL_SEL_IR 4'h9
`define ICL_CAP_IR 4'ha
`define ICL_SH_IR 4'hb
`define ICL_EX1_IR 4'hc
`define ICL_PA_IR 4'hd
`define ICL_EX2_IR 4'he
`define ICL_UPD_IR 4'hf
// ***********************************
// instruction codes
// ***********************************
`define ICL_I_ENTER 4'h1
`define ICL_I_CLAMP 4'h2
`define ICL_I_EXIT 4'h3
`define ICL_I_LDCLAMP 4'h4
`define ICL_I_ERASE 4'h5
`define ICL_I_ERASE_UFM 4'h6
`define ICL_I_PROG_CFM 4'h7
`define ICL_I_PROG_UFM 4'h8
`define ICL_I_READ_CFM 4'h9
`define ICL_I_READ_UFM 4'ha
`define ICL_I_SET_SEC 4'hb
`define ICL_I_SET_DONE 4'hc
`define ICL_I_RECONF 4'hd
`define ICL_I_RTISP 4'he
`define ICL_I_BYPASS 4'hf
`define ICL_IR_CAPTURE 4'h1
// ***********************************
// pending flash operations
// ***********************************
`define ICL_OP_NONE 3'h0
`define ICL_OP_ERASE 3'h1
`define ICL_OP_ERASE_UFM 3'h2
`define ICL_OP_PROG_CFM 3'h3
`define ICL_OP_PROG_UFM 3'h4
`define ICL_OP_SET_SEC 3'h5
`define ICL_OP_SET_DONE 3'h6
// ***********************************
// per pin clamp codes, field layout and reset values
// ***********************************
`define ICL_CL_FLOAT 2'h0
`define ICL_CL_LOW 2'h1
`define ICL_CL_HIGH 2'h2
`define ICL_CL_SAMPLE 2'h3
`define ICL_PIN_FLOAT 3'h1
`define ICL_DR_ADDR_LSB 16
`define ICL_DR_RST 20'h00000
`define ICL_ERASED 16'hffff
// ***********************************
// timing
// ***********************************
`define ICL_CLK_KHZ 125000
`define ICL_ERASE_MS 500
`define ICL_PROG_US 75
`define ICL_LOAD_US 450
`define ICL_ERASE_CYC (`ICL_ERASE_MS * `ICL_CLK_KHZ)
`define ICL_PROG_CYC ((`ICL_PROG_US * `ICL_CLK_KHZ + 999) / 1000)
`define ICL_LOAD_CYC ((`ICL_LOAD_US * `ICL_CLK_KHZ + 999) / 1000)
`endif

// ==== core/icl_tap.v ====
// jtag tap state machine, stepped by a sampled tck rising edge
// assumes tms is already synchronised to clock
`timescale 1ns/1ps
`default_nettype none
`include "icl_defs.vh"
module icl_tap (
  input wire clock, // system clock
  input wire reset, // async reset, high
  input wire ce, // clock enable
  input wire tck_rise, // one cycle per tck rising edge
  input wire tms, // synchronised mode select
  output reg [3:0] state_q // present tap state
);
  reg [3:0] state_d;
  // next state, standard sixteen state walk
  always @* begin
    state_d = state_q;
    case (state_q)
      `ICL_TLR: state_d = tms ? `ICL_TLR : `ICL_RTI;
      `ICL_RTI: state_d = tms ? `ICL_SEL_DR : `ICL_RTI;
      `ICL_SEL_DR: state_d = tms ? `ICL_SEL_IR : `ICL_CAP_DR;
      `ICL_CAP_DR: state_d = tms ? `ICL_EX1_DR : `ICL_SH_DR;
      `ICL_SH_DR: state_d = tms ? `ICL_EX1_DR : `ICL_SH_DR;
      `ICL_EX1_DR: state_d = tms ? `ICL_UPD_DR : `ICL_PA_DR;
      `ICL_PA_DR: state_d = tms ? `ICL_EX2_DR : `ICL_PA_DR;
      `ICL_EX2_DR: state_d = tms ? `ICL_UPD_DR : `ICL_SH_DR;
      `ICL_UPD_DR: state_d = tms ? `ICL_SEL_DR : `ICL_RTI;
      `ICL_SEL_IR: state_d = tms ? `ICL_TLR : `ICL_CAP_IR;
      `ICL_CAP_IR: state_d = tms ? `ICL_EX1_IR : `ICL_SH_IR;
      `ICL_SH_IR: state_d = tms ? `ICL_EX1_IR : `ICL_SH_IR;
      `ICL_EX1_IR: state_d = tms ? `ICL_UPD_IR : `ICL_PA_IR;
      `ICL_PA_IR: state_d = tms ? `ICL_EX2_IR : `ICL_PA_IR;
      `ICL_EX2_IR: state_d = tms ? `ICL_UPD_IR : `ICL_SH_IR;
      default: state_d = tms ? `ICL_SEL_DR : `ICL_RTI;
    endcase
  end
  // state register, moves only on a tck edge
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= `ICL_TLR;
    end else if (ce && tck_rise) begin
      state_q <= state_d;
    end
  end
endmodule
`default_nettype wire

// ==== sim/icl_top_properties.sv ====
// pin and mode checks for the isp clamp block
// assumes binding to icl_top with one clock domain
`timescale 1ns/1ps
`default_nettype none
module icl_top_properties (
  input wire logic clock, // system clock
  input wire logic reset, // async reset, high
  input wire logic tck, // jtag clock pin
  input wire logic [7:0] user_out, // user pin values
  input wire logic [7:0] user_oe, // user pin enables
  input wire logic [7:0] pin_out, // pin value
  input wire logic [7:0] pin_oe, // pin enable
  input wire logic [7:0] pin_pullup, // weak pull-ups
  input wire logic user_reset, // user register clear
  input wire logic isp_active // isp mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // reload start and isp exit, as steps
  sequence s_reload;
    $rose(user_reset) ##0 !isp_active;
  endsequence
  sequence s_exit;
    $fell(isp_active) ##0 !user_reset;
  endsequence
  load_float_a: assert property (
    user_reset |-> pin_oe == 8'h00 && pin_pullup == 8'hff)
    else $error("pins driven while loading");
  clear_first_a: assert property (
    $fell(user_reset) |-> pin_oe == 8'h00)
    else $error("pins released before clear ended");
  reload_hold_a: assert property (
    s_reload |-> user_reset [*8])
    else $error("reload shorter than load time");
  // pins show the isp state in the exit cycle, then float for one cycle
  exit_float_a: assert property (
    s_exit |=> pin_oe == 8'h00 && pin_pullup == 8'hff)
    else $error("pins not floated on isp exit");
  entry_run_a: assert property (
    $rose(isp_active) |-> !user_reset)
    else $error("isp entered while not running");
  isp_tck_a: assert property (
    $changed(isp_active) |-> tck)
    else $error("isp mode changed away from a tck edge");
  // a pin off isp is driven only where the user drives it
  drive_cause_a: assert property (
    !isp_active && !$past(isp_active) |-> (pin_oe & ~$past(user_oe)) == 8'h00)
    else $error("pin driven without user enable");
  out_value_a: assert property (
    !isp_active && !$past(isp_active) && !user_reset
      |-> (pin_out & pin_oe) == ($past(user_out) & pin_oe))
    else $error("pin value differs from user value");
endmodule
`default_nettype wire

// ==== sim/icl_prog.sv ====
// jtag programmer model for the tap pins of the block
// assumes the system clock; tck is 160 ns, low between frames
`timescale 1ns/1ps
`default_nettype none
module icl_prog (
  input wire logic clock, // system clock
  input wire logic tdo, // data from the block
  output logic tck, // jtag clock
  output logic tms, // mode select
  output logic tdi // data to the block
);
  // idle levels; tck stands low outside frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (10) @(posedge clock);
    tck <= 1'b1;
    q = tdo;
    repeat (10) @(posedge clock);
    tck <= 1'b0;
  endtask
  // walk the tap with a tms pattern, lsb first
  task automatic walk(input logic [7:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++) tick(m[i], 1'b0, q);
  endtask
  // shift n bits lsb first, leaving on the last
  task automatic shift(input logic [19:0] v, input int n, output logic [19:0] o);
    o = 20'h00000;
    for (int i = 0; i < n; i++) tick(i == n - 1, v[i], o[i]);
  endtask
  // waiting in run-test-idle times the pulses
  task automatic idle(input int n);
    walk(8'h00, n);
  endtask
  task automatic tlr();
    walk(8'h1f, 6);
  endtask
  task automatic ir(input logic [3:0] c);
    logic [19:0] o;
    walk(8'h03, 4);
    shift({16'h0000, c}, 4, o);
    walk(8'h01, 2);
  endtask
  task automatic dr(input logic [19:0] v, output logic [19:0] o);
    walk(8'h01, 3);
    shift(v, 20, o);
    walk(8'h01, 2);
  endtask
endmodule
`default_nettype wire

// ==== sim/icl_top_test.sv ====
// self-checking bench for the isp clamp block
// assumes icl_top, the programmer model and the checker
`timescale 1ns/1ps
`default_nettype none
`include "icl_defs.vh"
module icl_top_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ce;
  logic power_good;
  logic [7:0] user_out;
  logic [7:0] user_oe;
  logic [3:0] cfg_addr;
  logic [3:0] ufm_addr;
  logic tck, tms, tdi, tdo, tdo_oe, user_reset, isp_active;
  logic [7:0] pin_out, pin_oe, pin_pullup;
  logic [15:0] cfg_data, ufm_data, d;
  logic [19:0] o;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // short counts keep the pulses brief
  icl_top #(.ERASE_CYC(40), .PROG_CYC(20), .LOAD_CYC(20)) u_dut (
    .clock(clock), .reset(reset), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .power_good(power_good), .user_out(user_out),
    .user_oe(user_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .user_reset(user_reset), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .ufm_addr(ufm_addr), .ufm_data(ufm_data),
    .isp_active(isp_active));
  icl_prog u_prog (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  // clock and hang limit
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic float_chk();
    chk("pin_oe", 16'h0000, {8'h00, pin_oe});
    chk("pin_pullup", 16'h00ff, {8'h00, pin_pullup});
  endtask
  task automatic drive_chk(input logic [7:0] e_oe, input logic [7:0] e_out);
    chk("pin_oe", {8'h00, e_oe}, {8'h00, pin_oe});
    chk("pin_out", {8'h00, e_out & e_oe}, {8'h00, pin_out & e_oe});
  endtask
  // bounded wait for user mode
  task automatic wait_run();
    for (int i = 0; i < 400 && user_reset !== 1'b0; i++) @(posedge clock);
    chk("user_reset", 16'h0000, {15'h0000, user_reset});
    step(3);
  endtask
  task automatic rd(input logic [3:0] c, input logic [3:0] a);
    u_prog.ir(c);
    // tdo is enabled well inside the 20 bit shift
    fork
      u_prog.dr({a, 16'h0000}, o);
      begin
        step(160);
        chk("tdo_oe", 16'h0001, {15'h0000, tdo_oe});
      end
    join
    u_prog.dr({a, 16'h0000}, o);
    d = o[15:0];
    chk("tdo_oe", 16'h0000, {15'h0000, tdo_oe});
  endtask
  task automatic prog(input logic [3:0] c, input logic [19:0] v);
    u_prog.ir(c);
    u_prog.dr(v, o);
    u_prog.idle(2);
  endtask
  task automatic t_power();
    step(30);
    float_chk();
    chk("user_reset", 16'h0001, {15'h0000, user_reset});
    power_good <= 1'b1;
    wait_run();
    u_prog.tlr();
  endtask
  task automatic t_program();
    u_prog.ir(`ICL_I_ENTER);
    chk("isp_active", 16'h0001, {15'h0000, isp_active});
    float_chk();
    u_prog.ir(`ICL_I_ERASE);
    u_prog.idle(3);
    prog(`ICL_I_PROG_CFM, {4'h2, 16'h1234});
    prog(`ICL_I_PROG_UFM, {4'h3, 16'habcd});
    rd(`ICL_I_READ_CFM, 4'h2);
    chk("cfm_word", 16'h1234, d);
    rd(`ICL_I_READ_CFM, 4'h3);
    chk("cfm_word", 16'hffff, d);
    rd(`ICL_I_READ_UFM, 4'h3);
    chk("ufm_word", 16'habcd, d);
    u_prog.ir(`ICL_I_SET_DONE);
    u_prog.idle(2);
  endtask
  task automatic t_reload();
    u_prog.ir(`ICL_I_RECONF);
    chk("user_reset", 16'h0001, {15'h0000, user_reset});
    float_chk();
    // clock enable low freezes the load well past its length
    ce <= 1'b0;
    step(100);
    chk("user_reset", 16'h0001, {15'h0000, user_reset});
    float_chk();
    ce <= 1'b1;
    wait_run();
    cfg_addr <= 4'h2;
    user_out <= 8'h5a;
    user_oe <= 8'h0f;
    step(3);
    chk("cfg_data", 16'h1234, cfg_data);
    drive_chk(8'h0f, 8'h5a);
  endtask
  task automatic t_clamp();
    u_prog.ir(`ICL_I_LDCLAMP);
    u_prog.dr({4'h0, 16'h03e4}, o);
    user_out <= 8'h08;
    user_oe <= 8'h08;
    step(3);
    u_prog.ir(`ICL_I_CLAMP);
    drive_chk(8'h0e, 8'h0c);
    user_out <= 8'h00;
    user_oe <= 8'h00;
    step(4);
    drive_chk(8'h0e, 8'h0c);
    chk("pin_pullup", 16'h0011, {8'h00, pin_pullup & 8'h11});
    u_prog.ir(`ICL_I_EXIT);
    step(3);
    drive_chk(8'h00, 8'h00);
  endtask
  task automatic t_rtisp();
    user_out <= 8'h33;
    user_oe <= 8'hff;
    u_prog.ir(`ICL_I_RTISP);
    prog(`ICL_I_PROG_CFM, {4'h2, 16'h00ff});
    drive_chk(8'hff, 8'h33);
    chk("cfg_data", 16'h1234, cfg_data);
    u_prog.ir(`ICL_I_EXIT);
    step(3);
    chk("cfg_data", 16'h1234, cfg_data);
    // reload is only taken inside an access mode
    u_prog.ir(`ICL_I_RTISP);
    u_prog.ir(`ICL_I_RECONF);
    wait_run();
    chk("cfg_data", 16'h0034, cfg_data);
  endtask
  task automatic t_secure();
    u_prog.ir(`ICL_I_ENTER);
    u_prog.ir(`ICL_I_SET_SEC);
    u_prog.idle(2);
    rd(`ICL_I_READ_CFM, 4'h2);
    chk("cfm_word", 16'h0000, d);
    rd(`ICL_I_READ_UFM, 4'h3);
    chk("ufm_word", 16'habcd, d);
    ufm_addr <= 4'h3;
    step(3);
    chk("ufm_data", 16'habcd, ufm_data);
    u_prog.ir(`ICL_I_ERASE);
    u_prog.idle(3);
    rd(`ICL_I_READ_CFM, 4'h2);
    chk("cfm_word", 16'hffff, d);
    u_prog.ir(`ICL_I_EXIT);
  endtask
  // main sequence
  initial begin
    ce <= 1'b1;
    power_good <= 1'b0;
    user_out <= 8'h00;
    user_oe <= 8'h00;
    cfg_addr <= 4'h0;
    ufm_addr <= 4'h0;
    step(10);
    reset <= 1'b0;
    t_power();
    t_program();
    t_reload();
    t_clamp();
    t_rtisp();
    t_secure();
    report_and_stop();
  end
endmodule
bind icl_top icl_top_properties u_props (.clock(clock), .reset(reset), .tck(tck),
  .user_out(user_out), .user_oe(user_oe), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .user_reset(user_reset), .isp_active(isp_active));
`default_nettype wire
